// [rtl/multiqueue_read_flag_control.sv]
`timescale 1ns/1ps
// Circular buffer of flip-flops; level feeds the flag logic
module mq_queue_fifo #(
    parameter int WIDTH = 37,
    parameter int DEPTH = 16,
    parameter int LVL_W = 5
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [LVL_W-1:0] level
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [LVL_W-1:0] cnt_q, cnt_d;
    logic doPush, doPop;

    // Pointer and count update; full refuses, empty never pops
    always_comb
    begin
        inReady = (cnt_q != LVL_W'(DEPTH));
        outValid = (cnt_q != '0);
        doPush = inValid && inReady;
        doPop = outReady && outValid;
        wrPtr_d = doPush ? wrPtr_q + 1'b1 : wrPtr_q;
        rdPtr_d = doPop ? rdPtr_q + 1'b1 : rdPtr_q;
        cnt_d = cnt_q + LVL_W'(doPush) - LVL_W'(doPop);
        outData = mem_q[rdPtr_q];
        level = cnt_q;
    end

    // Storage has no reset; count and pointers define content
    always_ff @(posedge sys_clk)
    begin
        if (doPush)
        begin
            mem_q[wrPtr_q] <= inData;
        end
        if (rst)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

module multiqueue_read_flag_control #(
    parameter logic [2:0] DEVICE_ID = 3'h0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [mq_read_pkg::DATA_W-1:0] wrData,
    input wire logic wrEop,
    input wire logic wrSel,
    input wire logic [mq_read_pkg::ADDR_W-1:0] wrAddr,
    input wire logic rdEn,
    input wire logic rdSel,
    input wire logic [mq_read_pkg::ADDR_W-1:0] rdAddr,
    input wire logic packetMode,
    input wire logic outEnN,
    output logic [mq_read_pkg::DATA_W-1:0] dataOut,
    output logic dataOe,
    output logic outValidN,
    output logic outValidOe,
    output logic packetReadyN,
    output logic almostFullN,
    output logic almostFullOe,
    output logic almostEmptyN,
    output logic almostEmptyOe
);
    import mq_read_pkg::*;
    logic [QUEUES-1:0] push, pop, inReady, qValid;
    logic [DATA_W:0] head [QUEUES];
    logic [LVL_W-1:0] level [QUEUES];
    logic [LVL_W-1:0] pktCnt_q [QUEUES];
    logic [LVL_W-1:0] pktCnt_d [QUEUES];
    swState_t sw_q, sw_d;
    logic [QSEL_W-1:0] curQ_q, curQ_d, newQ_q, newQ_d, wrQ_q, wrQ_d;
    logic rdMine_q, rdMine_d, newMine_q, newMine_d, wrMine_q, wrMine_d;
    logic [DATA_W-1:0] outReg_q, outReg_d;
    logic invalid_q, invalid_d, prN_d;
    logic doPop;
    logic [QSEL_W-1:0] popQ;
    logic afRaw, afS1_q, afN_q, aeRaw, aeS1_q, aeN_q;

    // A queue may be read if it holds data, or a whole packet in packet mode
    function automatic logic availOf(input logic [QSEL_W-1:0] q, input logic mine);
        availOf = 1'b0;
        if (mine && q < NULL_Q)
        begin
            availOf = packetMode ? (pktCnt_q[q[1:0]] != '0) : qValid[q[1:0]];
        end
    endfunction

    // One buffer per queue; a write to a full buffer is dropped
    for (genvar i = 0; i < QUEUES; i++)
    begin : g_q
        assign push[i] = wrEn && wrMine_q && wrQ_q == QSEL_W'(i);
        assign pop[i] = doPop && popQ == QSEL_W'(i);
        mq_queue_fifo #(.WIDTH(DATA_W + 1), .DEPTH(DEPTH), .LVL_W(LVL_W)) u_fifo (
            .sys_clk(sys_clk),
            .rst(rst),
            .inValid(push[i]),
            .inReady(inReady[i]),
            .inData({wrEop, wrData}),
            .outValid(qValid[i]),
            .outReady(pop[i]),
            .outData(head[i]),
            .level(level[i])
        );
    end

    // Complete-packet count per queue: end marker in, end marker out
    always_comb
    begin
        for (int i = 0; i < QUEUES; i++)
        begin
            pktCnt_d[i] = pktCnt_q[i];
            if (push[i] && inReady[i] && wrEop)
            begin
                pktCnt_d[i] = pktCnt_d[i] + PKT_ONE;
            end
            if (pop[i] && head[i][DATA_W])
            begin
                pktCnt_d[i] = pktCnt_d[i] - PKT_ONE;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        for (int i = 0; i < QUEUES; i++)
        begin
            pktCnt_q[i] <= rst ? '0 : pktCnt_d[i];
        end
    end

    // Read pipeline: fall-through, queue switch and empty handling
    always_comb
    begin
        sw_d = sw_q;
        curQ_d = curQ_q;
        newQ_d = newQ_q;
        rdMine_d = rdMine_q;
        newMine_d = newMine_q;
        outReg_d = outReg_q;
        invalid_d = invalid_q;
        doPop = 1'b0;
        popQ = curQ_q;
        case (sw_q)
            SW_IDLE:
            begin
                if ((rdEn || invalid_q) && availOf(curQ_q, rdMine_q))
                begin
                    doPop = 1'b1;
                end
                else if (rdEn)
                begin
                    invalid_d = 1'b1;
                end
                if (rdSel)
                begin
                    sw_d = SW_OLD;
                    newQ_d = rdAddr[QSEL_W-1:0];
                    newMine_d = rdAddr[ADDR_W-1:QSEL_W] == DEVICE_ID;
                end
            end
            SW_OLD:
            begin
                sw_d = SW_NEW;
                if (availOf(curQ_q, rdMine_q))
                begin
                    doPop = 1'b1;
                end
                else
                begin
                    invalid_d = 1'b1;
                end
            end
            SW_NEW:
            begin
                sw_d = SW_IDLE;
                curQ_d = newQ_q;
                rdMine_d = newMine_q;
                popQ = newQ_q;
                if (availOf(newQ_q, newMine_q))
                begin
                    doPop = 1'b1;
                end
                else
                begin
                    invalid_d = 1'b1;
                end
            end
            default:
            begin
                sw_d = SW_IDLE;
            end
        endcase
        if (doPop)
        begin
            outReg_d = head[popQ[1:0]][DATA_W-1:0];
            invalid_d = 1'b0;
        end
        // Without a pop the register keeps its word
        prN_d = !(packetMode && availOf(curQ_d, rdMine_d));
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sw_q <= SW_IDLE;
            curQ_q <= NULL_Q;
            newQ_q <= NULL_Q;
            rdMine_q <= 1'b0;
            newMine_q <= 1'b0;
            outReg_q <= DATA_RST;
            invalid_q <= 1'b1;
            packetReadyN <= 1'b1;
        end
        else
        begin
            sw_q <= sw_d;
            curQ_q <= curQ_d;
            newQ_q <= newQ_d;
            rdMine_q <= rdMine_d;
            newMine_q <= newMine_d;
            outReg_q <= outReg_d;
            invalid_q <= invalid_d;
            packetReadyN <= prN_d;
        end
    end

    // Write queue select; a null or foreign address stops writes here
    always_comb
    begin
        wrQ_d = wrQ_q;
        wrMine_d = wrMine_q;
        if (wrSel)
        begin
            wrQ_d = wrAddr[QSEL_W-1:0];
            wrMine_d = wrAddr[ADDR_W-1:QSEL_W] == DEVICE_ID && wrAddr[QSEL_W-1:0] < NULL_Q;
        end
        // Flags are active low; a two-stage pipe gives the fixed latency
        afRaw = !(wrMine_q && wrQ_q < NULL_Q && level[wrQ_q[1:0]] >= AF_LEVEL);
        aeRaw = !(rdMine_q && curQ_q < NULL_Q && level[curQ_q[1:0]] <= AE_LEVEL);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wrQ_q <= NULL_Q;
            wrMine_q <= 1'b0;
            afS1_q <= 1'b1;
            afN_q <= 1'b1;
            aeS1_q <= 1'b1;
            aeN_q <= 1'b1;
        end
        else
        begin
            wrQ_q <= wrQ_d;
            wrMine_q <= wrMine_d;
            afS1_q <= afRaw;
            afN_q <= afS1_q;
            aeS1_q <= aeRaw;
            aeN_q <= aeS1_q;
        end
    end

    // Output enable is unclocked so the bus can be handed over at once
    assign dataOe = rdMine_q && !outEnN;
    assign dataOut = outReg_q;
    assign outValidN = invalid_q;
    assign outValidOe = rdMine_q;
    assign almostFullN = afN_q;
    assign almostFullOe = wrMine_q;
    assign almostEmptyN = aeN_q;
    assign almostEmptyOe = rdMine_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence selTaken;
        sw_q == SW_IDLE && rdSel;
    endsequence
    sequence nullTaken;
        selTaken and rdAddr[QSEL_W-1:0] == NULL_Q;
    endsequence
    // The switch edge lands two edges after the select, so it is sampled on the third
    newQueueTwo_a: assert property (selTaken |-> ##3 curQ_q == $past(rdAddr[2:0], 3))
        else $error("read queue not switched after two cycles");
    holdWord_a: assert property (sw_q == SW_IDLE && !rdEn && !rdSel && !invalid_q
        |=> $stable(dataOut))
        else $error("output word changed with reads disabled");
    emptyRaise_a: assert property (sw_q == SW_IDLE && rdEn && !availOf(curQ_q, rdMine_q)
        |=> outValidN && $stable(dataOut))
        else $error("valid flag not raised on empty read");
    refillFall_a: assert property (sw_q == SW_IDLE && invalid_q && availOf(curQ_q, rdMine_q)
        |=> !outValidN)
        else $error("valid flag not lowered after refill");
    nullEmpty_a: assert property (nullTaken |-> ##3 outValidN ##1 $stable(dataOut))
        else $error("null queue refilled the output");
    pktGate_a: assert property (packetMode && sw_q == SW_IDLE
        && pktCnt_q[curQ_q[1:0]] == '0 |-> pop == '0)
        else $error("word read before complete packet");
    prLead_a: assert property ($fell(outValidN) && packetMode |-> !packetReadyN)
        else $error("packet ready later than valid");
    afLatency_a: assert property (almostFullN == $past(afRaw, 2))
        else $error("almost-full latency not two cycles");
    aeLatency_a: assert property (almostEmptyN == $past(aeRaw, 2))
        else $error("almost-empty latency not two cycles");
    releaseBus_a: assert property (selTaken and rdAddr[5:3] != DEVICE_ID
        |-> ##3 !outValidOe && !dataOe)
        else $error("unselected device still drives");
endmodule

// [common/mq_read_pkg.sv]
package mq_read_pkg;
    localparam int DATA_W = 36;
    localparam int QUEUES = 4;
    localparam int DEPTH = 16;
    localparam int LVL_W = 5;
    localparam int QSEL_W = 3;
    localparam int DEV_W = 3;
    localparam int ADDR_W = 6;
    localparam logic [QSEL_W-1:0] NULL_Q = 3'h4;
    localparam logic [LVL_W-1:0] AF_LEVEL = 5'h0C;
    localparam logic [LVL_W-1:0] AE_LEVEL = 5'h02;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
    localparam logic [LVL_W-1:0] PKT_ONE = 5'h01;
    // Gray order along idle -> old word -> new word
    typedef enum logic [1:0] {SW_IDLE = 2'b00, SW_OLD = 2'b01, SW_NEW = 2'b11} swState_t;
endpackage

// [bench/host_model.sv]
`timescale 1ns/1ps
// Host side: queue selects and write traffic, all driven off the falling edge
module host_model (
    input wire logic sys_clk,
    output logic wrEn,
    output logic [mq_read_pkg::DATA_W-1:0] wrData,
    output logic wrEop,
    output logic wrSel,
    output logic [mq_read_pkg::ADDR_W-1:0] wrAddr,
    output logic rdSel,
    output logic [mq_read_pkg::ADDR_W-1:0] rdAddr
);
    import mq_read_pkg::*;
    // Both ports start parked on the null queue
    initial
    begin
        {wrEn, wrEop, wrSel, rdSel} = 4'h0;
        wrData = 36'h0;
        wrAddr = 6'h04;
        rdAddr = 6'h04;
    end
    // Switch cycle carries no write, so no packet marker can land on it
    task automatic wsel(input logic [ADDR_W-1:0] a);
        @(negedge sys_clk);
        wrEn = 1'b0;
        wrSel = 1'b1;
        wrAddr = a;
        @(negedge sys_clk);
        wrSel = 1'b0;
    endtask
    // Back-to-back writes: wrEn stays up until wend
    task automatic wr(input logic [DATA_W-1:0] d, input logic e);
        @(negedge sys_clk);
        wrEn = 1'b1;
        wrData = d;
        wrEop = e;
    endtask
    // Released data shows the inverse so a stale word never matches
    task automatic wend();
        @(negedge sys_clk);
        wrEn = 1'b0;
        wrData = ~wrData;
        wrEop = 1'b0;
    endtask
    // One-cycle select; callers leave at least two cycles before the next
    task automatic rsel(input logic [ADDR_W-1:0] a);
        @(negedge sys_clk);
        rdSel = 1'b1;
        rdAddr = a;
        @(negedge sys_clk);
        rdSel = 1'b0;
    endtask
endmodule

// [bench/multiqueue_read_flag_control_tb.sv]
`timescale 1ns/1ps
// Directed walk through read-side flag behaviour, data words drawn at random
module multiqueue_read_flag_control_tb;
    import mq_read_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic rdEn;
    logic packetMode;
    logic outEnN;
    logic wrEn, wrEop, wrSel, rdSel, dataOe, outValidN, outValidOe, packetReadyN;
    logic almostFullN, almostFullOe, almostEmptyN, almostEmptyOe;
    logic [DATA_W-1:0] wrData, dataOut;
    logic [ADDR_W-1:0] wrAddr, rdAddr;
    logic [31:0] seed = 32'hEF31187C;
    logic [DATA_W-1:0] w [16];
    int fails = 0;
    int checks = 0;
    int cyc = 0;

    always #12.5 sys_clk = ~sys_clk;

    // Hang guard: the sequence needs far fewer cycles than this
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            final_report();
        end
    end

    multiqueue_read_flag_control i_dut (
        .sys_clk,
        .rst,
        .wrEn,
        .wrData,
        .wrEop,
        .wrSel,
        .wrAddr,
        .rdEn,
        .rdSel,
        .rdAddr,
        .packetMode,
        .outEnN,
        .dataOut,
        .dataOe,
        .outValidN,
        .outValidOe,
        .packetReadyN,
        .almostFullN,
        .almostFullOe,
        .almostEmptyN,
        .almostEmptyOe
    );

    host_model i_host (
        .sys_clk,
        .wrEn,
        .wrData,
        .wrEop,
        .wrSel,
        .wrAddr,
        .rdSel,
        .rdAddr
    );

    // Xorshift; the top nibble reuses low bits to fill 36 bits
    function automatic logic [DATA_W-1:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return {seed[3:0], seed};
    endfunction

    // Expected active-low flag for a queue level
    function automatic logic flagN(input int lvl, input bit full);
        return full ? !(lvl >= AF_LEVEL) : !(lvl <= AE_LEVEL);
    endfunction

    // One bit wider than a word so a flag can ride along with the data
    task automatic chk(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic skip(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Bounded wait for a flag level; running out counts as a mismatch
    task automatic waitflag(input int s, input logic lvl);
        logic v;
        for (int i = 0; i < 16; i++)
        begin
            @(negedge sys_clk);
            v = s == 0 ? outValidN : s == 1 ? almostFullN : almostEmptyN;
            if (v === lvl)
                return;
        end
        chk(v, lvl);
    endtask

    task automatic final_report();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence: queue 0 gets words 0..2 and 7, queue 1 words 3..15, queue 2 words 8..11
    initial
    begin
        for (int i = 0; i < 16; i++)
            w[i] = rnd();
        // Random levels while in reset must leave no trace
        rdEn = w[0][0];
        packetMode = w[1][0];
        outEnN = w[2][0];
        skip(12);
        rst = 1'b0;
        rdEn = 1'b0;
        packetMode = 1'b0;
        outEnN = 1'b0;
        chk({dataOe, outValidN, packetReadyN, almostFullN, almostEmptyN}, 5'h0F);
        i_host.wsel(6'h00);
        for (int i = 0; i < 3; i++)
            i_host.wr(w[i], w[i][DATA_W-1]);
        i_host.wend();
        i_host.rsel(6'h00);
        skip(2);
        chk({outValidN, dataOut}, {1'b0, w[0]});
        chk(dataOe, 1'b1);
        #1 outEnN = 1'b1;
        #1 chk(dataOe, 1'b0);
        outEnN = 1'b0;
        skip(3);
        chk(dataOut, w[0]);
        i_host.wsel(6'h01);
        for (int i = 3; i < 16; i++)
            i_host.wr(w[i], w[i][DATA_W-1]);
        i_host.wend();
        waitflag(1, flagN(13, 1));
        i_host.wsel(6'h00);
        waitflag(1, flagN(2, 1));
        i_host.rsel(6'h01);
        skip(1);
        chk(dataOut, w[1]);
        skip(1);
        chk(dataOut, w[3]);
        waitflag(2, flagN(12, 0));
        i_host.rsel(6'h00);
        skip(1);
        chk(dataOut, w[4]);
        skip(1);
        chk(dataOut, w[2]);
        rdEn = 1'b1;
        skip(1);
        chk({outValidN, dataOut}, {1'b1, w[2]});
        rdEn = 1'b0;
        i_host.wr(w[7], 1'b0);
        i_host.wend();
        waitflag(0, 1'b0);
        chk(dataOut, w[7]);
        i_host.rsel(6'h04);
        skip(2);
        chk({outValidN, dataOut}, {1'b1, w[7]});
        i_host.rsel(6'h01);
        skip(2);
        chk(dataOut, w[5]);
        rdEn = 1'b1;
        waitflag(2, 1'b0);
        waitflag(0, 1'b1);
        chk(dataOut, w[15]);
        rdEn = 1'b0;
        // Any nonzero device field names a foreign device
        i_host.rsel({w[13][2:0] | 3'h1, w[13][5:3]});
        skip(2);
        chk({outValidOe, dataOe, almostEmptyOe}, 3'h0);
        i_host.wsel({w[12][2:0] | 3'h1, w[12][5:3]});
        chk(almostFullOe, 1'b0);
        packetMode = 1'b1;
        i_host.wsel(6'h02);
        i_host.wr(w[8], 1'b0);
        i_host.wr(w[9], 1'b0);
        i_host.wend();
        i_host.rsel(6'h02);
        skip(2);
        chk({outValidN, packetReadyN}, 2'h3);
        i_host.wr(w[10], 1'b1);
        i_host.wr(w[11], 1'b0);
        i_host.wend();
        waitflag(0, 1'b0);
        chk(packetReadyN, 1'b0);
        chk(dataOut, w[8]);
        rdEn = 1'b1;
        waitflag(0, 1'b1);
        chk(dataOut, w[10]);
        rdEn = 1'b0;
        final_report();
    end
endmodule
